// ==== core/dws_pkg.sv ====
package dws_pkg;

  // Bus framing constants.
  localparam logic [7:0] BCAST_ADDR   = 8'h90;
  localparam logic [4:0] HS_CODE_TOP  = 5'h01;
  localparam logic [3:0] ACK_BIT_IDX  = 4'h8;
  localparam logic [3:0] FIRST_BIT    = 4'h1;
  localparam logic [3:0] CNT_CLEAR    = 4'h0;

  // Values after reset.
  localparam logic [11:0] RST_CODE    = 12'h000;
  localparam logic [1:0]  RST_MODE    = 2'h0;

  // Field positions inside the control/high byte.
  localparam int MODE_HI_POS = 5;
  localparam int MODE_LO_POS = 4;
  localparam int CODE_TOP_HI = 3;

  // Output stage modes.
  typedef enum logic [1:0] {
    PD_NORMAL = 2'h0,
    PD_1K     = 2'h1,
    PD_100K   = 2'h2,
    PD_HIZ    = 2'h3
  } dws_pd_t;

  // Receiver states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_HIGH,
    ST_LOW
  } dws_state_t;

  // Converter word handed to the analog side.
  typedef struct packed {
    logic [1:0]  pwrdn_mode;
    logic [11:0] conv_code_bits;
  } dws_conv_t;

endpackage

// ==== core/dws_slave.sv ====
// Overview of operation
// - First byte after a start is compared as the address byte.
// - Upper six bits are the prefix, bit 1 device select, bit 0 direction.
// - Respond to the own address only when device select bit equals the select pin level.
// - Select pin level is captured once after reset and kept.
// - Broadcast address 10010000 is acknowledged regardless of select pin.
// - Ninth clock: addressed receiver holds data low during the high time.
// - Control/high byte: two zero bits, two mode bits, four code bits.
// - Following byte gives the eight low code bits.
// - Both data bytes are acknowledged; master waits for each.
// - Code and mode load on the falling edge ending the low-byte acknowledge.
// - Any number of byte pairs per transfer, each acknowledged and loaded.
// - After a low-byte acknowledge comes another high byte, a stop or a repeated start.
// - After stop, ignore traffic until start plus matching address.
// - Once addressed, stay receiving until a stop or a repeated start with a foreign address is seen.
// - Standard, fast and high-speed bit rates are all accepted.
// - Ten-bit addressing and general call are not answered.
// - Mode 00 normal, 01 1k, 10 100k, 11 open; code kept.
// - After reset the code is zero until the first complete write.
module dws_slave #(
  parameter logic [5:0] ADDR_PREFIX = 6'h15  // Arbitrary device-type prefix.
) (
  // System clock domain.
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ce_i,
  // Two-wire bus; the clock line is the link clock.
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output wire logic              sda_o,
  output wire logic              sda_oe_n_o,
  // Strap pin.
  input  wire logic              addr_select_pin_i,
  // Converter side.
  output dws_pkg::dws_conv_t     conv_o,
  output wire logic              conv_update_o,
  output wire logic              high_speed_mode_o,
  output wire logic              addr_sel_o
);

  // Link-domain reset, brought over from the system reset.
  logic rst_m_q;
  logic rst_l_q;
  always_ff @(posedge scl_i) begin
    rst_m_q <= sys_rst_i;
    rst_l_q <= rst_m_q;
  end

  // Start and stop are seen only as data edges while the clock is high, so they are
  // caught on the data line and handed over as toggles; the protocol keeps the clock
  // still around these edges, which gives the toggles time to settle.
  // The data line need not move during reset, so the toggles clear asynchronously.
  logic start_tog_q;
  logic stop_tog_q;
  always_ff @(negedge sda_i or posedge rst_l_q) begin
    if (rst_l_q) begin
      start_tog_q <= 1'b0;
    end else if (scl_i) begin
      start_tog_q <= ~start_tog_q;
    end
  end
  always_ff @(posedge sda_i or posedge rst_l_q) begin
    if (rst_l_q) begin
      stop_tog_q <= 1'b0;
    end else if (scl_i) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // Receiver state on the rising clock edge.
  dws_pkg::dws_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] hi_q, hi_d;
  logic       pend_q, pend_d;
  logic       hs_q, hs_d;
  logic       start_seen_q;
  logic       stop_seen_q;
  logic       a0_m_q;
  logic       a0_l_q;
  logic       a0_q;
  logic       start_new;
  logic       stop_new;
  logic       addr_hit;
  logic       bcast;
  logic       at_ack;
  logic       ack_want;
  logic [11:0] nxt_code;

  assign start_new = start_tog_q != start_seen_q;
  assign stop_new  = stop_tog_q != stop_seen_q;
  // General call and ten-bit headers never carry the prefix, so they fall through.
  assign addr_hit  = (sh_q[7:2] == ADDR_PREFIX) && (sh_q[1] == a0_l_q) && !sh_q[0];
  assign bcast     = sh_q == dws_pkg::BCAST_ADDR;
  assign at_ack    = cnt_q == dws_pkg::ACK_BIT_IDX;
  assign ack_want  = at_ack && ((state_q == dws_pkg::ST_ADDR) ? (addr_hit || bcast)
                                                              : (state_q != dws_pkg::ST_IDLE));
  assign nxt_code  = {hi_q[dws_pkg::CODE_TOP_HI:0], sh_q};

  // Next-state logic for byte reception and sequencing.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    hi_d    = hi_q;
    pend_d  = 1'b0;
    hs_d    = stop_new ? 1'b0 : hs_q;
    if (start_new) begin
      state_d = dws_pkg::ST_ADDR;
      cnt_d   = dws_pkg::FIRST_BIT;
      sh_d    = {sh_q[6:0], sda_i};
    end else if (stop_new) begin
      state_d = dws_pkg::ST_IDLE;
      cnt_d   = dws_pkg::CNT_CLEAR;
    end else if (state_q != dws_pkg::ST_IDLE) begin
      if (at_ack) begin
        cnt_d = dws_pkg::CNT_CLEAR;
        case (state_q)
          dws_pkg::ST_ADDR: begin
            state_d = ack_want ? dws_pkg::ST_HIGH : dws_pkg::ST_IDLE;
            if (sh_q[7:3] == dws_pkg::HS_CODE_TOP) begin
              hs_d = 1'b1;
            end
          end
          dws_pkg::ST_HIGH: begin
            hi_d    = sh_q;
            state_d = dws_pkg::ST_LOW;
          end
          dws_pkg::ST_LOW: begin
            pend_d  = 1'b1;
            state_d = dws_pkg::ST_HIGH;
          end
          default: begin
            state_d = dws_pkg::ST_IDLE;
          end
        endcase
      end else begin
        sh_d  = {sh_q[6:0], sda_i};
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // Rising-edge registers; the strap level crosses in by two flip-flops.
  always_ff @(posedge scl_i) begin
    a0_m_q <= a0_q;
    a0_l_q <= a0_m_q;
    if (rst_l_q) begin
      state_q      <= dws_pkg::ST_IDLE;
      cnt_q        <= dws_pkg::CNT_CLEAR;
      sh_q         <= 8'h00;
      hi_q         <= 8'h00;
      pend_q       <= 1'b0;
      hs_q         <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      sh_q         <= sh_d;
      hi_q         <= hi_d;
      pend_q       <= pend_d;
      hs_q         <= hs_d;
      start_seen_q <= start_tog_q;
      stop_seen_q  <= stop_tog_q;
    end
  end

  // Falling-edge side: acknowledge drive and converter load.
  logic              oe_n_q, oe_n_d;
  logic              upd_tog_q, upd_tog_d;
  dws_pkg::dws_conv_t lcode_q, lcode_d;
  always_comb begin
    oe_n_d    = ~ack_want;
    lcode_d   = lcode_q;
    upd_tog_d = upd_tog_q;
    if (pend_q) begin
      lcode_d.pwrdn_mode     = {hi_q[dws_pkg::MODE_HI_POS], hi_q[dws_pkg::MODE_LO_POS]};
      lcode_d.conv_code_bits = nxt_code;
      upd_tog_d              = ~upd_tog_q;
    end
  end
  always_ff @(negedge scl_i) begin
    if (rst_l_q) begin
      oe_n_q    <= 1'b1;
      lcode_q   <= '{pwrdn_mode: dws_pkg::RST_MODE, conv_code_bits: dws_pkg::RST_CODE};
      upd_tog_q <= 1'b0;
    end else begin
      oe_n_q    <= oe_n_d;
      lcode_q   <= lcode_d;
      upd_tog_q <= upd_tog_d;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = oe_n_q;

  // System side: three-stage synchronisers; an update counts when stages two and three differ, strap and speed once they agree.
  logic [2:0]        upd_s_q, a0_s_q, hs_s_q, a0_v_q;
  logic              strap_done_q;
  logic              upd_q;
  logic              hs_out_q;
  dws_pkg::dws_conv_t conv_q;
  logic              upd_evt;
  assign upd_evt = upd_s_q[1] ^ upd_s_q[2];
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      upd_s_q      <= 3'h0;
      a0_s_q       <= 3'h0;
      a0_v_q       <= 3'h0;
      hs_s_q       <= 3'h0;
      strap_done_q <= 1'b0;
      a0_q         <= 1'b0;
      upd_q        <= 1'b0;
      hs_out_q     <= 1'b0;
      conv_q       <= '{pwrdn_mode: dws_pkg::RST_MODE, conv_code_bits: dws_pkg::RST_CODE};
    end else if (ce_i) begin
      upd_s_q <= {upd_s_q[1:0], upd_tog_q};
      a0_s_q  <= {a0_s_q[1:0], addr_select_pin_i};
      a0_v_q  <= {a0_v_q[1:0], 1'b1};
      hs_s_q  <= {hs_s_q[1:0], hs_q};
      upd_q   <= upd_evt;
      if (upd_evt) begin
        conv_q <= lcode_q;
      end
      // The strap is taken only once the stages hold pin samples, not their reset zeros.
      if (!strap_done_q && a0_v_q[2] && (a0_s_q[1] == a0_s_q[2])) begin
        a0_q         <= a0_s_q[2];
        strap_done_q <= 1'b1;
      end
      if (hs_s_q[1] == hs_s_q[2]) begin
        hs_out_q <= hs_s_q[2];
      end
    end
  end

  assign conv_o            = conv_q;
  assign conv_update_o     = upd_q;
  assign high_speed_mode_o = hs_out_q;
  assign addr_sel_o        = a0_q;

  // Checks on the link side, then on the system side.
  sequence s_low_ack;
    state_q == dws_pkg::ST_LOW && at_ack;
  endsequence
  property p_start_addr;
    @(posedge scl_i) disable iff (rst_l_q) start_new |=> state_q == dws_pkg::ST_ADDR && cnt_q == 4'h1;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not open address phase");
  property p_ack_low;
    @(negedge scl_i) disable iff (rst_l_q) ack_want |=> !sda_oe_n_o;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("acknowledge not driven");
  property p_nack;
    @(negedge scl_i) disable iff (rst_l_q)
      (at_ack && state_q == dws_pkg::ST_ADDR && !addr_hit && !bcast) |=> sda_oe_n_o;
  endproperty
  a_nack: assert property (p_nack) else $error("foreign address acknowledged");
  property p_bcast;
    @(negedge scl_i) disable iff (rst_l_q) (at_ack && state_q == dws_pkg::ST_ADDR && bcast) |=> !sda_oe_n_o;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not acknowledged");
  property p_sel;
    @(negedge scl_i) disable iff (rst_l_q)
      (at_ack && state_q == dws_pkg::ST_ADDR && !bcast && sh_q[1] != a0_l_q) |=> sda_oe_n_o;
  endproperty
  a_sel: assert property (p_sel) else $error("select bit mismatch acknowledged");
  property p_high;
    @(posedge scl_i) disable iff (rst_l_q)
      (at_ack && state_q == dws_pkg::ST_HIGH && !start_new && !stop_new) |=> state_q == dws_pkg::ST_LOW;
  endproperty
  a_high: assert property (p_high) else $error("high byte not followed by low byte");
  property p_pair;
    @(posedge scl_i) disable iff (rst_l_q)
      (s_low_ack and (!start_new && !stop_new)) |=> state_q == dws_pkg::ST_HIGH && pend_q;
  endproperty
  a_pair: assert property (p_pair) else $error("pair did not request a load");
  property p_load;
    @(negedge scl_i) disable iff (rst_l_q) pend_q |=> lcode_q.conv_code_bits == $past(nxt_code);
  endproperty
  a_load: assert property (p_load) else $error("code not loaded after low byte");
  property p_stay;
    @(posedge scl_i) disable iff (rst_l_q)
      (state_q == dws_pkg::ST_HIGH && !at_ack && !start_new && !stop_new) |=> state_q == dws_pkg::ST_HIGH;
  endproperty
  a_stay: assert property (p_stay) else $error("left selected state without stop");
  property p_zero;
    @(posedge clk_sys_i) sys_rst_i |=> conv_o.conv_code_bits == dws_pkg::RST_CODE;
  endproperty
  a_zero: assert property (p_zero) else $error("code not cleared by reset");
  property p_strap;
    @(posedge clk_sys_i) disable iff (sys_rst_i) strap_done_q |=> $stable(addr_sel_o);
  endproperty
  a_strap: assert property (p_strap) else $error("strap changed after capture");

endmodule

// ==== tb/dws_bus_master.sv ====
module dws_bus_master (
  // Open-drain bus lines driven by the master; 1 releases the wire.
  output logic      scl_o,
  output logic      sda_o,
  // Resolved data wire.
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;

  // The bus idles with both lines released.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Clock pulse with data released, to carry the reset and the captured strap level into the link logic.
  task automatic idle_pulse();
    scl_o = 1'b0;
    #(2*Q) scl_o = 1'b1;
    #(2*Q);
  endtask

  // Data changes only while the clock is low and holds through the high time.
  task automatic clk_bit(input logic b, output logic s);
    sda_o = b;
    #Q scl_o = 1'b1;
    #Q s = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // Stop: data rises while the clock is high, and both lines then stand idle.
  task automatic stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #(2*Q);
  endtask

  // Eight bits first-bit-high, then a ninth clock with data released.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule

// ==== tb/dws_slave_tb_top.sv ====
module dws_slave_tb_top;
  timeunit 1ns;
  timeprecision 10ps;
  localparam logic [5:0] PFX = 6'h15;  // Arbitrary device-type prefix.
  logic               clk_sys_i, sys_rst_i, ce_i, strap, scl, m_sda, oe_n, sda_d, upd, hs, a_sel, a0;
  dws_pkg::dws_conv_t conv;
  logic [13:0]        cur_word;
  logic [13:0]        exp_q[$];
  logic [13:0]        got_q[$];
  int                 fail_count = 0;
  int                 total_checks = 0;
  integer             seed = 32'hdf1ce13f;
  // The data wire has a pull-up; either party may pull it low.
  wire                sda_w = m_sda & (oe_n | sda_d);

  dws_slave #(.ADDR_PREFIX(PFX)) dws_slave_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_d), .sda_oe_n_o(oe_n), .addr_select_pin_i(strap), .conv_o(conv),
    .conv_update_o(upd), .high_speed_mode_o(hs), .addr_sel_o(a_sel));
  dws_bus_master dws_bus_master_inst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));

  // System clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Every converter update is collected, so a stray or missing one is seen.
  always @(posedge clk_sys_i) if (upd === 1'b1) got_q.push_back(conv);

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One addressed phase with byte pairs; a negative mode means a random mode.
  task automatic xfer(input logic [7:0] adr, input int pairs, input int mode, input bit odd);
    logic        ack;
    logic        hit;
    logic [13:0] w;
    hit = (adr == {PFX, a0, 1'b0}) || (adr == 8'h90);
    dws_bus_master_inst.start();
    dws_bus_master_inst.send_byte(adr, ack);
    check("addr_ack", ack, hit);
    for (int i = 0; i < pairs + odd; i++) begin
      w = 14'($random(seed));
      if (mode >= 0) w[13:12] = mode[1:0];
      dws_bus_master_inst.send_byte({2'b00, w[13:8]}, ack);
      check("high_ack", ack, hit);
      if (i < pairs) begin
        dws_bus_master_inst.send_byte(w[7:0], ack);
        check("low_ack", ack, hit);
        if (hit) begin
          exp_q.push_back(w);
          cur_word = w;
        end
      end
    end
  endtask

  // Stop, then compare every update and the held word with the model.
  task automatic finish_xfer();
    int n;
    dws_bus_master_inst.stop();
    n = 0;
    while (got_q.size() < exp_q.size() && n < 30) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (got_q.size() < exp_q.size()) begin
      fail_count++;
      finish_test();
    end
    repeat (6) @(posedge clk_sys_i);
    check("update_count", got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0) check("conv_word", got_q.pop_front(), exp_q.pop_front());
    check("conv_held", conv, cur_word);
    got_q.delete();
    exp_q.delete();
  endtask

  // A hang ends the run as a failure.
  initial begin
    #5000000;
    fail_count++;
    finish_test();
  end

  // Reset with link pulses, then the scenarios.
  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    strap = 1'($random(seed));
    a0 = strap;
    cur_word = 14'h0000;
    fork
      repeat (3) dws_bus_master_inst.idle_pulse();
      repeat (8) @(negedge clk_sys_i);
    join
    sys_rst_i = 1'b0;
    check("conv_reset", conv, 14'h0000);
    repeat (8) @(negedge clk_sys_i);
    check("strap", a_sel, a0);
    strap = ~a0;
    repeat (2) dws_bus_master_inst.idle_pulse();
    xfer({PFX, a0, 1'b0}, 2, -1, 0);
    finish_xfer();
    xfer({PFX, ~a0, 1'b0}, 1, -1, 0);
    finish_xfer();
    xfer({PFX, a0, 1'b1}, 1, -1, 0);
    finish_xfer();
    xfer(8'h00, 1, -1, 0);
    finish_xfer();
    xfer(8'h90, 1, -1, 0);
    finish_xfer();
    xfer({PFX, ~a0, 1'b0}, 1, -1, 0);
    xfer({PFX, a0, 1'b0}, 1, -1, 1);
    finish_xfer();
    for (int m = 0; m < 4; m++) begin
      xfer({PFX, a0, 1'b0}, 1, m, 0);
      finish_xfer();
    end
    // With the enable low the system side must hold the update back until it returns.
    @(negedge clk_sys_i);
    ce_i = 1'b0;
    xfer({PFX, a0, 1'b0}, 1, -1, 0);
    repeat (10) @(posedge clk_sys_i);
    check("frozen_update", got_q.size(), 0);
    @(negedge clk_sys_i);
    ce_i = 1'b1;
    finish_xfer();
    xfer({5'h01, 3'($random(seed))}, 0, -1, 0);
    repeat (6) @(posedge clk_sys_i);
    check("hs_set", hs, 1'b1);
    xfer({PFX, a0, 1'b0}, 1, -1, 0);
    check("hs_hold", hs, 1'b1);
    finish_xfer();
    xfer({PFX, a0, 1'b0}, 0, -1, 0);
    check("hs_clear", hs, 1'b0);
    finish_xfer();
    finish_test();
  end
endmodule
